//--- hw/tcu_pkg.sv
package tcu_pkg;
    localparam int TCU_NCH = 8;
    localparam int TCU_NWIN = 4;
    localparam int TCU_NWIN_LOGIC = 2;
    localparam int TCU_NBLK = 16;
    localparam int TCU_CLK_HZ = 25_000_000;
    localparam int TCU_RETEST_MS = 1000;
    localparam int TCU_RETEST_CYC = TCU_CLK_HZ / 1000 * TCU_RETEST_MS;
    localparam logic signed [7:0] TCU_PCT_MAX = 8'sh64;
    localparam logic signed [7:0] TCU_PCT_MIN = -8'sh64;
    localparam logic [3:0] TCU_CH_OFF = 4'h0;
    localparam logic [3:0] TCU_CH_LOGIC_A = 4'h9;
    localparam logic [3:0] TCU_CH_LOGIC_B = 4'hA;

    typedef enum logic [1:0] {TCU_TYPE_WINDOW, TCU_TYPE_PERCH, TCU_TYPE_EXT} tcu_type_t;
    typedef enum logic [1:0] {TCU_ACT_MEMORY, TCU_ACT_RECORD, TCU_ACT_CHART} tcu_action_t;
    typedef enum logic [1:0] {TCU_SLOPE_RISE, TCU_SLOPE_FALL, TCU_SLOPE_HIGH, TCU_SLOPE_LOW}
        tcu_slope_t;
    typedef enum logic [1:0] {TCU_REC_FREE, TCU_REC_SINGLE, TCU_REC_REPEAT} tcu_rec_mode_t;
    typedef enum logic [1:0] {TCU_CAP_FREE, TCU_CAP_SINGLE, TCU_CAP_SEQ, TCU_CAP_ROT}
        tcu_cap_mode_t;

    // ch: 0 off, 1..8 analog channel, 9/10 logic inputs
    typedef struct packed {
        logic [3:0] ch;
        tcu_slope_t slope;
        logic signed [7:0] level;
    } tcu_win_cond_t;

    typedef struct packed {
        logic en;
        tcu_slope_t slope;
        logic signed [7:0] level;
    } tcu_ch_cond_t;

    function automatic logic signed [7:0] tcu_clamp_pct(input logic signed [7:0] v);
        if (v > TCU_PCT_MAX) begin
            return TCU_PCT_MAX;
        end else if (v < TCU_PCT_MIN) begin
            return TCU_PCT_MIN;
        end
        return v;
    endfunction
endpackage

//--- hw/tcu_cond_eval.sv
`timescale 1ns/1ps
module tcu_cond_eval import tcu_pkg::*; (
    // sample pair of the watched input, signed percent of range
    input wire logic signed [7:0] cur,
    input wire logic signed [7:0] prev,
    // condition
    input wire tcu_slope_t slope,
    input wire logic signed [7:0] level,
    // result
    output logic hit
);
    logic signed [7:0] lvl;

    always_comb begin
        lvl = tcu_clamp_pct(level);
        case (slope)
            TCU_SLOPE_RISE: hit = (prev < lvl) && (cur >= lvl);
            TCU_SLOPE_FALL: hit = (prev > lvl) && (cur <= lvl);
            TCU_SLOPE_HIGH: hit = cur > lvl;
            default: hit = cur < lvl;
        endcase
    end
endmodule

//--- hw/tcu_top.sv
`timescale 1ns/1ps
// How it works
// - window type holds four conditions, two for logic inputs, channels may repeat.
// - per-channel type holds one condition for each input channel.
// - external type triggers on the chosen edge of the external input.
// - trigger starts capture, starts recording, or switches chart to second speed.
// - AND combining needs every enabled condition true together.
// - OR combining needs any one enabled condition true.
// - slope selects rising crossing, falling crossing, above or below threshold.
// - threshold is a signed percent of range, limited to -100..100.
// - chart speed: re-test every second, keep while true, revert within two seconds.
// - chart speed switch acts only while recording runs.
// - a second chart speed given in mm/h is refused.
// - with record action, capture cannot start during recording.
// - chart-speed action ignores the record mode setting.
// - record free mode starts and stops on key or external start.
// - record single arms on key, trigger starts, key or fixed length stops.
// - record repeat returns to waiting after fixed length, restarts on trigger.
// - capture free uses next block per press; after last, discard all, restart.
// - capture single waits for trigger after each key press, and that trigger fills one block.
// - repeat sequence fills blocks per trigger, stops when all full.
// - repeat rotate fills blocks, then overwrites from block one cyclically.
// - the next block is cleared while waiting, before the trigger.
// - capture mode may change during recording, touching only capture.
// - with pre-trigger, triggers ignored until pre-trigger memory full.
module tcu_top import tcu_pkg::*; #(
    parameter int NCH = TCU_NCH,
    parameter int NBLK = TCU_NBLK,
    parameter int RETEST_CYC = TCU_RETEST_CYC,
    localparam int BW = $clog2(NBLK)
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // sample stream, one signed percent per channel
    input wire logic sample_valid,
    input wire logic [NCH-1:0][7:0] ch_sample,
    // pins from outside the clock domain
    input wire logic logic_a_pin,
    input wire logic logic_b_pin,
    input wire logic ext_trig_pin,
    input wire logic ext_start_pin,
    // trigger configuration
    input wire tcu_type_t trig_type,
    input wire tcu_action_t action,
    input wire logic combine_and,
    input wire tcu_win_cond_t [TCU_NWIN-1:0] win_cond,
    input wire tcu_ch_cond_t [NCH-1:0] per_channel_cond,
    input wire logic ext_fall,
    input wire logic speed2_mmh,
    // recording control
    input wire tcu_rec_mode_t rec_mode,
    input wire logic rec_key,
    input wire logic fixed_len_en,
    input wire logic rec_len_done,
    // capture control
    input wire tcu_cap_mode_t cap_mode,
    input wire logic mem_key,
    input wire logic pre_en,
    input wire logic pre_full,
    input wire logic blk_full,
    input wire logic [BW-1:0] blk_last,
    // status
    output logic recording,
    output logic capturing,
    output logic chart_fast,
    output logic armed,
    output logic trig_ready,
    output logic trig_seen,
    output logic speed2_reject,
    output logic [BW-1:0] cap_block,
    output logic blk_clear,
    output logic discard_all
);
    initial begin
        if (NCH < 1 || NCH > 8 || NBLK < 2 || RETEST_CYC < 2) begin
            $error("tcu_top: unsupported parameter values");
        end
    end

    typedef enum {R_IDLE, R_WAIT, R_RUN} tcu_rec_st_t;
    typedef enum {C_IDLE, C_PRE, C_WAIT, C_FILL} tcu_cap_st_t;

    localparam int SYNC_W = 4;
    localparam logic signed [7:0] LOGIC_HI = TCU_PCT_MAX;
    localparam logic signed [7:0] LOGIC_LO = TCU_PCT_MIN;

    // pin synchronisers: a change counts once stages two and three agree
    logic [SYNC_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg <= '0;
        end else if (ce) begin
            sync1_reg <= {ext_start_pin, ext_trig_pin, logic_b_pin, logic_a_pin};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < SYNC_W; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    logic [SYNC_W-1:0] pin_prev_reg;
    logic [NCH-1:0][7:0] prev_sample_reg;
    logic [1:0] prev_logic_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= '0;
            prev_sample_reg <= '0;
            prev_logic_reg <= '0;
        end else if (ce) begin
            pin_prev_reg <= pin_reg;
            if (sample_valid) begin
                prev_sample_reg <= ch_sample;
                prev_logic_reg <= pin_reg[1:0];
            end
        end
    end

    function automatic logic signed [7:0] pick(input logic [3:0] ch,
                                               input logic [NCH-1:0][7:0] s,
                                               input logic [1:0] lg);
        if (ch == TCU_CH_LOGIC_A) begin
            return lg[0] ? LOGIC_HI : LOGIC_LO;
        end else if (ch == TCU_CH_LOGIC_B) begin
            return lg[1] ? LOGIC_HI : LOGIC_LO;
        end else if (ch != TCU_CH_OFF && int'(ch) <= NCH) begin
            return $signed(s[ch - 4'h1]);
        end
        return '0;
    endfunction

    logic [TCU_NWIN-1:0] win_hit, win_use;
    logic [NCH-1:0] ch_hit;
    for (genvar w = 0; w < TCU_NWIN; w++) begin : g_win
        logic lg;
        assign lg = win_cond[w].ch == TCU_CH_LOGIC_A || win_cond[w].ch == TCU_CH_LOGIC_B;
        // logic inputs only in the first two slots; analog slots may repeat channels
        assign win_use[w] = win_cond[w].ch != TCU_CH_OFF
            && (!lg || w < TCU_NWIN_LOGIC) && (lg || int'(win_cond[w].ch) <= NCH);
        tcu_cond_eval u_eval (
            .cur(pick(win_cond[w].ch, ch_sample, pin_reg[1:0])),
            .prev(pick(win_cond[w].ch, prev_sample_reg, prev_logic_reg)),
            .slope(win_cond[w].slope),
            .level(win_cond[w].level),
            .hit(win_hit[w])
        );
    end
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        tcu_cond_eval u_eval (
            .cur($signed(ch_sample[c])),
            .prev($signed(prev_sample_reg[c])),
            .slope(per_channel_cond[c].slope),
            .level(per_channel_cond[c].level),
            .hit(ch_hit[c])
        );
    end

    logic [NCH-1:0] ch_use;
    logic cond_now, ext_edge;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ch_use[c] = per_channel_cond[c].en;
        end
        // edge taken from the filtered pin, so a bouncing edge counts once
        ext_edge = ext_fall ? (pin_prev_reg[2] && !pin_reg[2])
                            : (pin_reg[2] && !pin_prev_reg[2]);
        cond_now = 1'b0;
        if (trig_type == TCU_TYPE_EXT) begin
            cond_now = ext_edge;
        end else if (trig_type == TCU_TYPE_WINDOW) begin
            cond_now = sample_valid && (win_use != '0) && (combine_and
                ? ((win_hit & win_use) == win_use)
                : ((win_hit & win_use) != '0));
        end else begin
            cond_now = sample_valid && (ch_use != '0) && (combine_and
                ? ((ch_hit & ch_use) == ch_use)
                : ((ch_hit & ch_use) != '0));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_seen <= 1'b0;
        end else if (ce) begin
            trig_seen <= cond_now;
        end
    end

    // ---- record sequencing
    tcu_rec_st_t rec_state;
    logic ext_start_edge, rec_toggle, rec_trig;
    assign ext_start_edge = pin_reg[3] && !pin_prev_reg[3];
    assign rec_toggle = rec_key || ext_start_edge;
    assign rec_trig = trig_seen && action == TCU_ACT_RECORD;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rec_state <= R_IDLE;
        end else if (ce) begin
            case (rec_state)
                R_IDLE: begin
                    if (rec_toggle) begin
                        // free mode, or chart/memory action, runs straight away
                        rec_state <= (action == TCU_ACT_RECORD && rec_mode != TCU_REC_FREE)
                            ? R_WAIT : R_RUN;
                    end
                end
                R_WAIT: begin
                    if (rec_toggle) begin
                        rec_state <= R_IDLE;
                    end else if (rec_trig) begin
                        rec_state <= R_RUN;
                    end
                end
                default: begin
                    if (rec_toggle) begin
                        rec_state <= R_IDLE;
                    end else if (fixed_len_en && rec_len_done
                                 && action == TCU_ACT_RECORD) begin
                        if (rec_mode == TCU_REC_REPEAT) begin
                            rec_state <= R_WAIT;
                        end else if (rec_mode == TCU_REC_SINGLE) begin
                            rec_state <= R_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ---- chart speed switching, tested once per retest period
    logic [$clog2(RETEST_CYC)-1:0] sec_cnt;
    logic seen_in_sec;
    logic chart_ok;
    assign chart_ok = action == TCU_ACT_CHART && rec_state == R_RUN && !speed2_mmh;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            chart_fast <= 1'b0;
            sec_cnt <= '0;
            seen_in_sec <= 1'b0;
            speed2_reject <= 1'b0;
        end else if (ce) begin
            speed2_reject <= speed2_mmh;
            if (!chart_ok) begin
                chart_fast <= 1'b0;
                sec_cnt <= '0;
                seen_in_sec <= 1'b0;
            end else if (!chart_fast) begin
                if (trig_seen) begin
                    chart_fast <= 1'b1;
                    sec_cnt <= '0;
                    seen_in_sec <= 1'b0;
                end
            end else if (int'(sec_cnt) == RETEST_CYC - 1) begin
                // a miss over a whole period drops back, so revert lags at most two periods
                chart_fast <= seen_in_sec || trig_seen;
                sec_cnt <= '0;
                seen_in_sec <= 1'b0;
            end else begin
                sec_cnt <= sec_cnt + 1'b1;
                seen_in_sec <= seen_in_sec || trig_seen;
            end
        end
    end

    // ---- capture sequencing; cap_mode is read live so it may change mid-recording
    tcu_cap_st_t cap_state;
    logic cap_trig, cap_start_ok, cap_last, fill_end;
    assign cap_trig = trig_seen && action == TCU_ACT_MEMORY;
    assign cap_start_ok = !(action == TCU_ACT_RECORD && rec_state == R_RUN);
    assign cap_last = cap_block == blk_last;
    assign fill_end = cap_state == C_FILL && (mem_key || blk_full);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_state <= C_IDLE;
            cap_block <= '0;
            blk_clear <= 1'b0;
            discard_all <= 1'b0;
        end else if (ce) begin
            blk_clear <= 1'b0;
            discard_all <= 1'b0;
            case (cap_state)
                C_IDLE: begin
                    if (mem_key && cap_start_ok) begin
                        blk_clear <= 1'b1;
                        if (cap_mode == TCU_CAP_FREE || action != TCU_ACT_MEMORY) begin
                            cap_state <= C_FILL;
                        end else begin
                            cap_state <= pre_en ? C_PRE : C_WAIT;
                        end
                    end
                end
                C_PRE: begin
                    if (mem_key) begin
                        cap_state <= C_IDLE;
                    end else if (pre_full) begin
                        cap_state <= C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (mem_key) begin
                        cap_state <= C_IDLE;
                    end else if (cap_trig) begin
                        cap_state <= C_FILL;
                    end
                end
                default: begin
                    if (fill_end) begin
                        if (cap_last) begin
                            cap_block <= '0;
                            // rotate overwrites one by one, others restart clean
                            discard_all <= cap_mode != TCU_CAP_ROT;
                        end else begin
                            cap_block <= cap_block + 1'b1;
                        end
                        if (mem_key || cap_mode == TCU_CAP_FREE || cap_mode == TCU_CAP_SINGLE
                            || (cap_mode == TCU_CAP_SEQ && cap_last)) begin
                            cap_state <= C_IDLE;
                        end else begin
                            blk_clear <= 1'b1;
                            cap_state <= pre_en ? C_PRE : C_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            recording <= 1'b0;
            capturing <= 1'b0;
            armed <= 1'b0;
            trig_ready <= 1'b0;
        end else if (ce) begin
            recording <= rec_state == R_RUN;
            capturing <= cap_state != C_IDLE;
            armed <= rec_state == R_WAIT || cap_state == C_WAIT;
            trig_ready <= cap_state == C_WAIT;
        end
    end

    // ---- checks
    property p_armed;
        @(posedge clock) disable iff (!rst_n)
        ce |=> armed == ($past(rec_state) == R_WAIT || $past(cap_state) == C_WAIT);
    endproperty
    a_armed: assert property (p_armed) else $error("armed mismatch");

    property p_no_cap_in_rec;
        @(posedge clock) disable iff (!rst_n)
        ce && cap_state == C_IDLE && action == TCU_ACT_RECORD && rec_state == R_RUN
        |=> cap_state == C_IDLE;
    endproperty
    a_no_cap_in_rec: assert property (p_no_cap_in_rec) else $error("capture in rec");

    property p_chart_needs_rec;
        @(posedge clock) disable iff (!rst_n)
        ce && rec_state != R_RUN |=> !chart_fast;
    endproperty
    a_chart_needs_rec: assert property (p_chart_needs_rec) else $error("chart idle");

    property p_mmh;
        @(posedge clock) disable iff (!rst_n)
        ce && speed2_mmh |=> !chart_fast && speed2_reject;
    endproperty
    a_mmh: assert property (p_mmh) else $error("mm/h speed accepted");

    property p_seq_stop;
        @(posedge clock) disable iff (!rst_n)
        ce && cap_state == C_FILL && blk_full && !mem_key && cap_mode == TCU_CAP_SEQ
        && cap_last |=> cap_state == C_IDLE && cap_block == '0 && discard_all;
    endproperty
    a_seq_stop: assert property (p_seq_stop) else $error("sequence did not stop");

    property p_rot_wrap;
        @(posedge clock) disable iff (!rst_n)
        ce && cap_state == C_FILL && blk_full && !mem_key && cap_mode == TCU_CAP_ROT
        && cap_last |=> cap_block == '0 && !discard_all && cap_state != C_IDLE;
    endproperty
    a_rot_wrap: assert property (p_rot_wrap) else $error("rotate wrap wrong");

    property p_clear_on_wait;
        @(posedge clock) disable iff (!rst_n)
        $rose(cap_state == C_WAIT || cap_state == C_PRE) |-> blk_clear;
    endproperty
    a_clear_on_wait: assert property (p_clear_on_wait) else $error("block not cleared");

    property p_pre_holds;
        @(posedge clock) disable iff (!rst_n)
        ce && cap_state == C_PRE && !pre_full && !mem_key |=> cap_state == C_PRE ##1 !trig_ready;
    endproperty
    a_pre_holds: assert property (p_pre_holds) else $error("trigger during pre fill");

    property p_rep_rearm;
        @(posedge clock) disable iff (!rst_n)
        ce && rec_state == R_RUN && !rec_toggle && fixed_len_en && rec_len_done
        && action == TCU_ACT_RECORD && rec_mode == TCU_REC_REPEAT |=> rec_state == R_WAIT;
    endproperty
    a_rep_rearm: assert property (p_rep_rearm) else $error("repeat did not rearm");

    c_rot_wrap: cover property (@(posedge clock) disable iff (!rst_n)
        cap_mode == TCU_CAP_ROT && fill_end && cap_last);
    c_chart: cover property (@(posedge clock) disable iff (!rst_n) $fell(chart_fast));
    c_rec_run: cover property (@(posedge clock) disable iff (!rst_n)
        rec_state == R_WAIT ##1 rec_state == R_RUN);
endmodule

//--- verification/tcu_src.sv
`timescale 1ns/1ps
module tcu_src import tcu_pkg::*; (
    // clock
    input wire logic clock,
    // sample stream and pins
    output logic sample_valid,
    output logic [TCU_NCH-1:0][7:0] ch_sample,
    output logic ext_trig_pin,
    output logic logic_a_pin,
    output logic logic_b_pin
);
    initial begin
        sample_valid = 1'b0;
        ch_sample = '0;
        ext_trig_pin = 1'b0;
        logic_a_pin = 1'b0;
        logic_b_pin = 1'b0;
    end
    // data is inverted between strobes so stale use shows up
    task automatic send(input logic [TCU_NCH-1:0][7:0] v);
        @(negedge clock);
        sample_valid = 1'b1;
        ch_sample = v;
        @(negedge clock);
        sample_valid = 1'b0;
        ch_sample = ~v;
    endtask
    task automatic set_ext(input logic lvl);
        @(negedge clock);
        ext_trig_pin = lvl;
    endtask
endmodule

//--- verification/trigger_control_unit_test.sv
`timescale 1ns/1ps
module trigger_control_unit_test import tcu_pkg::*;;
    logic clock = 1'b0, rst_n = 1'b0, sample_valid, ext_trig_pin, logic_a_pin, logic_b_pin;
    logic [TCU_NCH-1:0][7:0] ch_sample, v;
    tcu_type_t trig_type = TCU_TYPE_PERCH;
    tcu_action_t action = TCU_ACT_MEMORY;
    tcu_rec_mode_t rec_mode = TCU_REC_SINGLE;
    tcu_cap_mode_t cap_mode = TCU_CAP_SINGLE;
    tcu_win_cond_t [TCU_NWIN-1:0] win_cond = '0;
    tcu_ch_cond_t [TCU_NCH-1:0] per_channel_cond = '0;
    logic combine_and = 1'b0, ext_fall = 1'b0, speed2_mmh = 1'b0, rec_key = 1'b0;
    logic ce = 1'b1, mem_key = 1'b0, pre_en = 1'b0, blk_full = 1'b0, seen;
    logic [3:0] blk_last = 4'hF, cap_block, exp_blk;
    logic recording, capturing, chart_fast, armed, trig_ready, trig_seen;
    logic speed2_reject, blk_clear, discard_all;
    logic exp_q[$];
    logic [31:0] r = 32'hADF8A123;
    int error_cnt = 0, comparisons = 0, lv, p, c;
    always #20 clock = ~clock;
    tcu_src src (.clock(clock), .sample_valid(sample_valid), .ch_sample(ch_sample),
        .ext_trig_pin(ext_trig_pin), .logic_a_pin(logic_a_pin), .logic_b_pin(logic_b_pin));
    tcu_top #(.NCH(TCU_NCH), .NBLK(16), .RETEST_CYC(20)) dut (.clock(clock), .rst_n(rst_n),
        .ce(ce), .sample_valid(sample_valid), .ch_sample(ch_sample),
        .logic_a_pin(logic_a_pin), .logic_b_pin(logic_b_pin), .ext_trig_pin(ext_trig_pin),
        .ext_start_pin(1'b0), .trig_type(trig_type), .action(action),
        .combine_and(combine_and), .win_cond(win_cond), .per_channel_cond(per_channel_cond),
        .ext_fall(ext_fall), .speed2_mmh(speed2_mmh), .rec_mode(rec_mode), .rec_key(rec_key),
        .fixed_len_en(1'b0), .rec_len_done(1'b0), .cap_mode(cap_mode), .mem_key(mem_key),
        .pre_en(pre_en), .pre_full(1'b0), .blk_full(blk_full), .blk_last(blk_last),
        .recording(recording), .capturing(capturing), .chart_fast(chart_fast), .armed(armed),
        .trig_ready(trig_ready), .trig_seen(trig_seen), .speed2_reject(speed2_reject),
        .cap_block(cap_block), .blk_clear(blk_clear), .discard_all(discard_all));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic model_hit(input tcu_slope_t s, input int a, input int b, input int t);
        case (s)
            TCU_SLOPE_RISE: return a < t && b > t;
            TCU_SLOPE_FALL: return a > t && b < t;
            TCU_SLOPE_HIGH: return b > t;
            default: return b < t;
        endcase
    endfunction
    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic check_blk(input string name, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // trig_seen may already stand on entry, so sample before waiting
    task automatic watch(input int n);
        seen = trig_seen;
        repeat (n) begin
            @(negedge clock);
            seen = seen | trig_seen;
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask
    task automatic send_ch0(input int val);
        r = lfsr(r);
        v = {r, ~r};
        v[0] = val[7:0];
        src.send(v);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        check_bit("armed", 1'b0, armed);
        // edges and levels against random thresholds; odd samples never equal even levels
        for (int i = 0; i < 12; i++) begin
            r = lfsr(r);
            lv = (int'(r[5:0]) % 50) * 2 - 50;
            p = (int'(r[13:8]) % 50) * 2 - 49;
            c = (int'(r[21:16]) % 50) * 2 - 49;
            per_channel_cond[0] = '{1'b1, tcu_slope_t'(i % 4), lv[7:0]};
            exp_q.push_back(model_hit(tcu_slope_t'(i % 4), p, c, lv));
            send_ch0(p);
            repeat (3) @(negedge clock);
            send_ch0(c);
            watch(3);
            check_bit("trig_seen", exp_q.pop_front(), seen);
        end
        $display("test slopes done");
        trig_type = TCU_TYPE_WINDOW;
        win_cond[0] = '{4'h1, TCU_SLOPE_HIGH, -8'sh14};
        win_cond[1] = '{4'h1, TCU_SLOPE_LOW, 8'sh14};
        for (int i = 0; i < 4; i++) begin
            combine_and = i[0];
            c = i[1] ? 50 : 0;
            send_ch0(c);
            watch(3);
            check_bit("trig_seen", i[1] ? !i[0] : 1'b1, seen);
            repeat (3) @(negedge clock);
        end
        $display("test window done");
        trig_type = TCU_TYPE_EXT;
        for (int f = 0; f < 2; f++) begin
            ext_fall = f[0];
            src.set_ext(1'b1);
            watch(8);
            check_bit("trig_seen", !f[0], seen);
            src.set_ext(1'b0);
            watch(8);
            check_bit("trig_seen", f[0], seen);
        end
        $display("test external done");
        trig_type = TCU_TYPE_PERCH;
        per_channel_cond[0] = '{1'b1, TCU_SLOPE_HIGH, 8'h00};
        exp_blk = 4'h0;
        blk_last = 4'h1;
        for (int n = 0; n < 2; n++) begin
            cap_mode = n[0] ? TCU_CAP_SEQ : TCU_CAP_SINGLE;
            pulse(mem_key);
            check_bit("blk_clear", 1'b1, blk_clear);
            check_blk("cap_block", exp_blk, cap_block);
            @(negedge clock);
            check_bit("armed", 1'b1, armed);
            check_bit("trig_ready", 1'b1, trig_ready);
            send_ch0(50);
            repeat (3) @(negedge clock);
            check_bit("capturing", 1'b1, capturing);
            check_bit("armed", 1'b0, armed);
            pulse(blk_full);
            check_bit("discard_all", n[0], discard_all);
            repeat (2) @(negedge clock);
            exp_blk = (exp_blk == blk_last) ? 4'h0 : exp_blk + 4'h1;
            check_bit("capturing", 1'b0, capturing);
            check_blk("cap_block", exp_blk, cap_block);
        end
        $display("test capture done");
        action = TCU_ACT_RECORD;
        rec_mode = TCU_REC_REPEAT;
        pulse(rec_key);
        @(negedge clock);
        check_bit("armed", 1'b1, armed);
        check_bit("recording", 1'b0, recording);
        send_ch0(50);
        repeat (3) @(negedge clock);
        check_bit("recording", 1'b1, recording);
        pulse(mem_key);
        repeat (3) @(negedge clock);
        check_bit("capturing", 1'b0, capturing);
        pulse(rec_key);
        repeat (3) @(negedge clock);
        check_bit("recording", 1'b0, recording);
        $display("test record done");
        action = TCU_ACT_CHART;
        speed2_mmh = 1'b1;
        repeat (2) @(negedge clock);
        check_bit("speed2_reject", 1'b1, speed2_reject);
        send_ch0(50);
        repeat (3) @(negedge clock);
        check_bit("chart_fast", 1'b0, chart_fast);
        speed2_mmh = 1'b0;
        pulse(rec_key);
        repeat (3) @(negedge clock);
        check_bit("recording", 1'b1, recording);
        send_ch0(50);
        repeat (3) @(negedge clock);
        check_bit("chart_fast", 1'b1, chart_fast);
        ce = 1'b0;
        repeat (45) @(negedge clock);
        check_bit("chart_fast", 1'b1, chart_fast);
        ce = 1'b1;
        repeat (45) @(negedge clock);
        check_bit("chart_fast", 1'b0, chart_fast);
        $display("test chart done");
        tally_and_finish();
    end
endmodule
